// file: src/wdg_config_guard.sv
// Watchdog configuration guard: APB slave holding run bit and period select,
// with the timed unlock window and two safety levels.
// Assumes always_on_fuse is static, osc_tick comes from the watchdog oscillator pin.
//
// Behaviour
// R01: Level 1: watchdog off after reset.
// R02: Level 1: writing run bit one enables directly.
// R03: Level 1: period change/disable needs unlock.
// R04: Unlock write sets unlock and run both.
// R05: Level 1: next write within four cycles applies.
// R06: Level 2: always running, run reads one.
// R07: Level 2: only period changes via unlock.
// R08: Level 2: unlock still needs run bit one.
// R09: Level 2: run bit ignored in window write.
// R10: Unlock bit self-clears after four cycles.
// R11: Select picks 16K..2048K oscillator cycles.
// R12: Count cleared by kick, disable, reset.
// R13: Expiry without kick issues system reset.
// R14: Static level; locked writes change nothing.
module wdg_config_guard
    import wdg_guard_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic always_on_fuse,
    input wire logic osc_clk_pin,
    input wire logic kick_instruction,
    output logic system_reset_req
);
    import wdg_guard_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] fuse_sync_ff;
    logic [1:0] osc_sync_ff;
    logic osc_prev_ff;
    logic level2_ff;
    logic level_taken_ff;
    logic [1:0] fill_ff;

    // Two flops each; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_sync_ff <= 2'h0;
            osc_sync_ff <= 2'h0;
            osc_prev_ff <= 1'b0;
        end
        else
        begin
            fuse_sync_ff <= {fuse_sync_ff[0], always_on_fuse};
            osc_sync_ff <= {osc_sync_ff[0], osc_clk_pin};
            osc_prev_ff <= osc_sync_ff[1];
        end
    end

    logic osc_tick;
    assign osc_tick = osc_sync_ff[1] && !osc_prev_ff;

    // Level latched once the synchroniser holds the pin, not its reset value;
    // later fuse changes ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level2_ff <= 1'b0;
            level_taken_ff <= 1'b0;
            fill_ff <= 2'h0;
        end
        else
        begin
            fill_ff <= {fill_ff[0], 1'b1};
            if (fill_ff[1] && !level_taken_ff)
            begin
                level2_ff <= fuse_sync_ff[1]; // R14
                level_taken_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_access;
    logic rd_access;
    logic ctrl_wr;
    logic kick_wr;
    logic known_addr;

    assign pready = 1'b1; // Zero wait states
    assign known_addr = (paddr == ctrl_addr) || (paddr == status_addr)
        || (paddr == kick_addr);
    assign pslverr = psel && penable && !known_addr;
    assign wr_access = psel && penable && pwrite && known_addr;
    assign rd_access = psel && penable && !pwrite;
    assign ctrl_wr = wr_access && (paddr == ctrl_addr);
    assign kick_wr = wr_access && (paddr == kick_addr);

    logic w_unlock;
    logic w_run;
    logic [period_w-1:0] w_period;
    assign w_unlock = pwdata[unlock_bit_pos];
    assign w_run = pwdata[run_bit_pos];
    assign w_period = pwdata[period_lsb +: period_w];

    // ------------------------------------------------------------
    // Unlock window
    // ------------------------------------------------------------
    win_state_t win_ff;
    logic [2:0] win_cnt_ff;
    logic open_req;

    // Opening needs unlock and run both written as one
    assign open_req = ctrl_wr && w_unlock && w_run; // R04 R08

    // Window spans the four cycles after the unlock write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_ff <= win_closed;
            win_cnt_ff <= 3'h0;
        end
        else
        begin
            case (win_ff)
                win_closed:
                    if (open_req)
                    begin
                        win_ff <= win_open;
                        win_cnt_ff <= 3'h0;
                    end
                win_open:
                    if (open_req)
                        win_cnt_ff <= 3'h0; // Re-arm restarts the window
                    else if (ctrl_wr
                        || win_cnt_ff == unlock_window_last - 3'h1)
                        win_ff <= win_closed; // R10
                    else
                        win_cnt_ff <= win_cnt_ff + 3'h1;
                default:
                    win_ff <= win_closed;
            endcase
        end
    end

    logic window_hit;
    assign window_hit = (win_ff == win_open) && ctrl_wr && !w_unlock;

    // ------------------------------------------------------------
    // Run bit and period select
    // ------------------------------------------------------------
    logic run_ff;
    logic [period_w-1:0] period_ff;
    logic run_eff;

    // Level 2 forces running regardless of stored bit
    assign run_eff = run_ff || level2_ff; // R06

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff <= 1'b0; // R01
            period_ff <= period_reset;
        end
        else if (window_hit)
        begin
            period_ff <= w_period; // R05 R07 R09
            if (!level2_ff)
                run_ff <= w_run; // R03 R05
        end
        else if (ctrl_wr && w_run)
            run_ff <= 1'b1; // R02
        // Other locked writes fall through unchanged
    end // R14

    // ------------------------------------------------------------
    // Counter and reset request
    // ------------------------------------------------------------
    logic expire;
    logic fired_ff;

    wdg_counter #(
        .count_width(count_w)
    ) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .osc_tick(osc_tick),
        .run(run_eff),
        .kick(kick_instruction || kick_wr), // R12
        .period_sel(period_ff),
        .expire(expire)
    );

    // Registered one-cycle reset request to the system
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            system_reset_req <= 1'b0;
            fired_ff <= 1'b0;
        end
        else
        begin
            system_reset_req <= expire; // R13
            if (expire)
                fired_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0;
            if (paddr == ctrl_addr)
            begin
                prdata[period_lsb +: period_w] <= period_ff;
                prdata[run_bit_pos] <= run_eff; // R06
                prdata[unlock_bit_pos] <= (win_ff == win_open);
            end
            else if (paddr == status_addr)
            begin
                prdata[status_armed_pos] <= run_eff;
                prdata[status_level2_pos] <= level2_ff;
                prdata[status_fired_pos] <= fired_ff;
            end
        end
        else if (!rd_access)
            prdata <= 32'h0;
    end
endmodule

// file: src/wdg_guard_pkg.sv
// Constants shared by the watchdog configuration guard and its counter.
// Assumes a 40 MHz APB clock and a separate watchdog oscillator tick input.
package wdg_guard_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, 32-bit aligned words)
    // ------------------------------------------------------------
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] status_addr = 12'h004;
    localparam logic [11:0] kick_addr = 12'h008;

    // ------------------------------------------------------------
    // Control and status word field layout
    // ------------------------------------------------------------
    localparam int period_lsb = 0;
    localparam int period_w = 3;
    localparam int run_bit_pos = 3;
    localparam int unlock_bit_pos = 4;
    localparam int status_armed_pos = 0;
    localparam int status_level2_pos = 1;
    localparam int status_fired_pos = 2;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [2:0] period_reset = 3'h0;
    localparam int unlock_window_cycles = 4;
    localparam logic [2:0] unlock_window_last = 3'(unlock_window_cycles);
    localparam int base_timeout_kcycles = 16;
    localparam int count_w = 22;

    typedef enum logic [1:0] {
        win_closed,
        win_open
    } win_state_t;

endpackage

// file: src/wdg_counter.sv
// Watchdog count: advances on oscillator ticks, expires at the chosen period.
// Assumes osc_tick is a one-cycle pulse already synchronised to pclk.
module wdg_counter
    import wdg_guard_pkg::*;
#(
    parameter int count_width = wdg_guard_pkg::count_w
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_tick,
    input wire logic run,
    input wire logic kick,
    input wire logic [wdg_guard_pkg::period_w-1:0] period_sel,
    output logic expire
);
    import wdg_guard_pkg::*;

    logic [count_width-1:0] count_ff;
    logic [count_width-1:0] limit;

    // 16K cycles shifted by the select: 16K .. 2048K, doubling each step
    assign limit = count_width'((base_timeout_kcycles * 1024) << period_sel); // R11

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Cleared by kick, disable and reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_ff <= '0; // R12
        else if (kick || !run || expire)
            count_ff <= '0; // R12
        else if (osc_tick)
            count_ff <= count_ff + count_width'(1);
    end

    // Expiry pulse; compare with limit-1 so the period is exact
    assign expire = run && osc_tick && (count_ff == limit - count_width'(1)); // R13
endmodule

// file: tb/wdg_guard_sva.sv
// Checker for the watchdog configuration guard, top-level ports only.
// Assumes the fuse input stays put between resets.
module wdg_guard_sva
    import wdg_guard_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic always_on_fuse,
    input wire logic osc_clk_pin,
    input wire logic kick_instruction,
    input wire logic system_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import wdg_guard_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, rd_ctrl, ok_addr, run_seen_ff;
    logic [3:0] since_unlock_ff;
    assign acc = psel && penable;
    assign rd_ctrl = acc && !pwrite && paddr == ctrl_addr;
    assign ok_addr = paddr inside {ctrl_addr, status_addr, kick_addr};
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Saturating age of the last unlock write, so a stale window shows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            since_unlock_ff <= 4'hf;
            run_seen_ff <= 1'b0;
        end
        else
        begin
            if (acc && pwrite && paddr == ctrl_addr && pwdata[4] && pwdata[3])
                since_unlock_ff <= 4'h0;
            else if (since_unlock_ff != 4'hf)
                since_unlock_ff <= since_unlock_ff + 4'h1;
            if (acc && pwrite && paddr == ctrl_addr && pwdata[3])
                run_seen_ff <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_off; !always_on_fuse && !run_seen_ff && rd_ctrl |-> !prdata[3]; endproperty
    a_off: assert property (p_off) else $error("run set without a run write");
    property p_l2run; always_on_fuse && rd_ctrl |-> prdata[3]; endproperty
    a_l2run: assert property (p_l2run) else $error("level 2 run reads zero");
    property p_l2st;
        always_on_fuse && acc && !pwrite && paddr == status_addr |-> prdata[1:0] == 2'h3;
    endproperty
    a_l2st: assert property (p_l2st) else $error("level 2 status wrong");
    property p_win; rd_ctrl && prdata[4] |-> since_unlock_ff <= 4'h5; endproperty
    a_win: assert property (p_win) else $error("unlock window stays open");
    property p_quiet; !always_on_fuse && !run_seen_ff |-> !system_reset_req; endproperty
    a_quiet: assert property (p_quiet) else $error("reset from idle watchdog");
    property p_pulse; system_reset_req |=> !system_reset_req; endproperty
    a_pulse: assert property (p_pulse) else $error("reset request too long");
    property p_bad; acc && !ok_addr |-> pslverr; endproperty
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    property p_good; acc && ok_addr |-> !pslverr && pready; endproperty
    a_good: assert property (p_good) else $error("mapped access refused");
    property p_idle; !$past(psel) |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data left on bus");
endmodule

bind wdg_config_guard wdg_guard_sva u_wdg_guard_sva (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .always_on_fuse(always_on_fuse),
    .osc_clk_pin(osc_clk_pin),
    .kick_instruction(kick_instruction),
    .system_reset_req(system_reset_req)
);

// file: tb/testbench.sv
// Self-checking bench for the watchdog configuration guard.
// Drives APB, fuse, oscillator and kick itself; no far-side model.
module testbench
    import wdg_guard_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse = 0;
    logic osc = 0, kick = 0, osc_run = 0, pready, pslverr, req, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d, rnd = 32'hbad1deb2;
    int miscompares = 0, compares = 0, ticks = 0, t0, lag;
    wdg_config_guard u_wdg_config_guard (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .always_on_fuse(fuse),
        .osc_clk_pin(osc), .kick_instruction(kick), .system_reset_req(req));
    // ------------------------------------------------------------
    // Clock, oscillator and helpers
    // ------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    // Fast oscillator, one tick per two clocks, counted at the pin
    always @(posedge pclk)
    begin
        if (osc_run)
        begin
            osc <= ~osc;
            ticks <= ticks + (osc ? 0 : 1);
        end
    end
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    // Expected control readback: level 2 always reads as running
    function automatic logic [31:0] exp_ctrl(input logic [2:0] p, input logic r, input logic l2);
        return {27'h0, 1'b0, r | l2, p};
    endfunction
    // Oscillator ticks for a period select: 16K, doubled per step
    function automatic int exp_ticks(input logic [2:0] p);
        return (base_timeout_kcycles * 1024) << p;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Unlock, then one window write, then read back
    task automatic seq(input logic [2:0] p, input logic r, input logic l2);
        xfer(1'b1, ctrl_addr, 32'h18);
        xfer(1'b1, ctrl_addr, {28'h0, r, p});
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, exp_ctrl(p, r, l2));
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Expiry test needs about 67000 clocks; the rest is a few hundred
    initial
    begin
        repeat (80000) @(posedge pclk);
        miscompares++;
        conclude();
    end
    initial
    begin
        do_reset();
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h0);
        xfer(1'b0, status_addr, 32'h0);
        chk(d & 32'h3, 32'h0);
        xfer(1'b1, ctrl_addr, 32'h0d);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h08);
        xfer(1'b1, ctrl_addr, 32'h03);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h08);
        $display("test 1 done");
        for (int i = 0; i < 8; i++)
            seq(3'(i), 1'(xs()), 1'b0);
        seq(3'h7, 1'b1, 1'b0);
        xfer(1'b1, ctrl_addr, 32'h18);
        repeat (5) @(posedge pclk);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h10, 32'h0);
        xfer(1'b1, ctrl_addr, 32'h02);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h0f);
        xfer(1'b1, ctrl_addr, 32'h18);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h10, 32'h10);
        // Window write taken on the fourth edge still lands
        xfer(1'b1, ctrl_addr, 32'h18);
        @(posedge pclk);
        xfer(1'b1, ctrl_addr, 32'h01);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h01);
        // One edge later it is refused
        xfer(1'b1, ctrl_addr, 32'h18);
        repeat (2) @(posedge pclk);
        xfer(1'b1, ctrl_addr, 32'h04);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h09);
        xfer(1'b1, 12'h00c, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test 2 done");
        seq(3'h0, 1'b1, 1'b0);
        osc_run <= 1'b1;
        // Register kick early; without it expiry would precede the status read
        while (ticks < 2000) @(posedge pclk);
        xfer(1'b1, kick_addr, 32'h0);
        while (ticks < 17000) @(posedge pclk);
        xfer(1'b0, status_addr, 32'h0);
        chk(d & 32'h7, 32'h1);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        t0 = ticks;
        while (req !== 1'b1) @(posedge pclk);
        lag = ticks - t0 - exp_ticks(3'h0);
        chk(32'(lag >= -2 && lag <= 3), 32'h1);
        osc_run <= 1'b0;
        xfer(1'b0, status_addr, 32'h0);
        chk(d & 32'h7, 32'h5);
        $display("test 3 done");
        fuse <= 1'b1;
        do_reset();
        xfer(1'b0, status_addr, 32'h0);
        chk(d & 32'h3, 32'h3);
        xfer(1'b1, ctrl_addr, 32'h05);
        xfer(1'b0, ctrl_addr, 32'h0);
        chk(d & 32'h1f, 32'h08);
        for (int i = 0; i < 8; i++)
            seq(3'(7 - i), xs() & 32'h1, 1'b1);
        $display("test 4 done");
        conclude();
    end
endmodule
